// >>> hw/dcr_pkg.sv
// Constants, field layout and carrier types for the transceiver control register bank
// Overview of operation
// - Frame sizes, clock M and O, code period and polynomial go live only when register 172 is written or rewritten, and after load.
// - After reset the saved volatile or non-volatile image is loaded automatically.
// - Stored frequency zero is 32-bit hertz in registers 0..3, low byte first.
// - Frequencies one to seven occupy registers 3+4x to 6+4x, same format.
// - Register 6 holds rx index 2:0, tx index 6:4; retune on its write.
// - Rx RF gain 12 bits in registers 4 and 5(3:0); applied on register 5 write.
// - Rx IF gain 12 bits in registers 35 and 36(3:0); applied on register 36 write.
// - LNA gain 10 bits in registers 40 and 41(1:0); applied on register 41 write.
// - Tx level target 12 bits in registers 37 and 38(3:0); applied on 38 write.
// - Register 39 bits select LNA, RF and IF loops: zero fixed, one automatic.
// - Register 43 bit 0 powers block supply, bit 1 picks 13 V or 18 V.
// - Register 46 bits 1..3 enable front, downconverter and transmit reference clocks.
// - Register 47 bit 0 enables encoding, bit 1 decoding; zero bypasses.
// - Rate codes in 164(3:0) and 168(3:0) map 0..7 to 1/3 through 7/8.
// - Frame sizes are 15 bits in 165/166(6:0) and 169/170(6:0).
// - Processing clock divider D in 48(6:0), M in 49/50, O in 51/52.
// - Chip rate exponent n, 1 to 15, sits in register 53(3:0).
// - Code period 16 bits in registers 54 and 55, 3 to 65535.
// - Register 56(3:0) selects Gold, maximal length, Barker or navigation code.
// - First generator polynomial is a 24-bit tap mask, bit 0 constant term.
// - Every control register is eight bits wide, readable and writable.
package dcr_pkg;
	localparam int NUM_REGS = 173;
	localparam logic [7:0] LAST_REG = 8'had;
	localparam logic [7:0] IMAGE_MARK = 8'h5a;
	localparam logic [7:0] A_RF_GAIN_LO = 8'h04;
	localparam logic [7:0] A_RF_GAIN_HI = 8'h05;
	localparam logic [7:0] A_FREQ_SEL = 8'h06;
	localparam logic [7:0] A_IF_GAIN_LO = 8'h23;
	localparam logic [7:0] A_IF_GAIN_HI = 8'h24;
	localparam logic [7:0] A_TX_LVL_LO = 8'h25;
	localparam logic [7:0] A_TX_LVL_HI = 8'h26;
	localparam logic [7:0] A_GAIN_LOOP = 8'h27;
	localparam logic [7:0] A_LNA_GAIN_LO = 8'h28;
	localparam logic [7:0] A_LNA_GAIN_HI = 8'h29;
	localparam logic [7:0] A_SUPPLY = 8'h2b;
	localparam logic [7:0] A_REF_CLK = 8'h2e;
	localparam logic [7:0] A_FEC_EN = 8'h2f;
	localparam logic [7:0] A_CLK_DIV = 8'h30;
	localparam logic [7:0] A_CLK_MULT_LO = 8'h31;
	localparam logic [7:0] A_CLK_MULT_HI = 8'h32;
	localparam logic [7:0] A_CLK_POST_LO = 8'h33;
	localparam logic [7:0] A_CLK_POST_HI = 8'h34;
	localparam logic [7:0] A_CHIP_EXP = 8'h35;
	localparam logic [7:0] A_PERIOD_LO = 8'h36;
	localparam logic [7:0] A_PERIOD_HI = 8'h37;
	localparam logic [7:0] A_CODE_SEL = 8'h38;
	localparam logic [7:0] A_POLY_B0 = 8'h39;
	localparam logic [7:0] A_POLY_B1 = 8'h3a;
	localparam logic [7:0] A_POLY_B2 = 8'h3b;
	localparam logic [7:0] A_ENC_PAYLOAD = 8'ha2;
	localparam logic [7:0] A_ENC_RATE = 8'ha4;
	localparam logic [7:0] A_ENC_FRAME_LO = 8'ha5;
	localparam logic [7:0] A_ENC_FRAME_HI = 8'ha6;
	localparam logic [7:0] A_DEC_PAYLOAD = 8'ha7;
	localparam logic [7:0] A_DEC_RATE = 8'ha8;
	localparam logic [7:0] A_DEC_FRAME_LO = 8'ha9;
	localparam logic [7:0] A_DEC_FRAME_HI = 8'haa;
	localparam logic [7:0] A_DEC_ITER = 8'hab;
	localparam logic [7:0] A_COMMIT = 8'hac;
	// Writable bit masks of partly used registers
	localparam logic [7:0] M_NIBBLE = 8'h0f;
	localparam logic [7:0] M_TWO = 8'h03;
	localparam logic [7:0] M_FREQ_SEL = 8'h77;
	localparam logic [7:0] M_GAIN_LOOP = 8'h4f;
	localparam logic [7:0] M_REF_CLK = 8'h0e;
	localparam logic [7:0] M_SEVEN = 8'h7f;
	localparam logic [7:0] M_THREE = 8'h07;
	localparam logic [7:0] M_FULL = 8'hff;
	// Field positions
	localparam int B_LNA_LOOP = 0;
	localparam int B_RF_LOOP = 1;
	localparam int B_TX_ON = 6;
	localparam int B_SUPPLY_ON = 0;
	localparam int B_SUPPLY_18V = 1;
	localparam int B_FRONT_CLK = 1;
	localparam int B_LNB_CLK = 2;
	localparam int B_TX_CLK = 3;
	localparam int B_ENC_EN = 0;
	localparam int B_DEC_EN = 1;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} dcr_req_t;

	typedef struct packed {
		logic [31:0] rx_freq_hz;
		logic [31:0] tx_freq_hz;
		logic [11:0] rf_gain;
		logic [11:0] if_gain;
		logic [9:0] lna_gain;
		logic [11:0] tx_level_target;
		logic lna_agc_on;
		logic rf_agc_on;
		logic [1:0] if_agc_mode;
		logic tx_on;
		logic block_supply_on;
		logic block_supply_18v;
		logic front_reference_clock_output;
		logic block_downconverter_clock_output;
		logic tx_reference_clock_output;
		logic fec_enc_en;
		logic fec_dec_en;
		logic [7:0] enc_payload_bytes;
		logic [3:0] enc_rate;
		logic [14:0] enc_frame_bits;
		logic [7:0] dec_payload_bytes;
		logic [3:0] dec_rate;
		logic [14:0] dec_frame_bits;
		logic [7:0] dec_max_iter;
		logic [6:0] clk_div;
		logic [9:0] clk_mult;
		logic [10:0] clk_postdiv;
		logic [3:0] chip_rate_exp;
		logic [15:0] code_period;
		logic [3:0] code_select;
		logic [23:0] first_generator_polynomial;
	} dcr_cfg_t;
endpackage

// >>> hw/dcr_regs.sv
// Control register bank with save images, power-up load and active shadow fields
`timescale 1ns/10ps
module dcr_regs #(
	parameter int NUM_FREQ = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire dcr_pkg::dcr_req_t req,
	input wire logic save_config_volatile_cmd,
	input wire logic save_config_nonvolatile_cmd,
	output logic [7:0] rdata,
	output logic rvalid,
	output logic busy,
	output dcr_pkg::dcr_cfg_t cfg
);
	import dcr_pkg::*;

	// Refused at elaboration: the select fields address exactly eight entries
	if (NUM_FREQ != 8) begin
		$error("dcr_regs supports exactly eight stored frequencies");
	end

	typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_SAVE} dcr_state_t;

	// ************************************************************
	// Storage
	// ************************************************************
	logic [7:0] regs [0:NUM_REGS-1];
	logic [7:0] vol_image [0:NUM_REGS];
	logic [7:0] nv_image [0:NUM_REGS];
	dcr_state_t state;
	logic [7:0] idx;
	logic save_nv;
	logic load_done;
	logic apply_sel;
	logic apply_rf;
	logic apply_if;
	logic apply_lna;
	logic apply_tx;
	logic apply_single;
	logic apply_commit;
	logic [7:0] load_byte;
	logic host_wr;
	logic [7:0] wmask;
	logic [7:0] rx_base;
	logic [7:0] tx_base;

	// Bits that a write may touch; the rest stay zero
	always_comb begin
		case (req.addr)
			A_RF_GAIN_HI, A_IF_GAIN_HI, A_TX_LVL_HI: wmask = M_NIBBLE;
			A_FREQ_SEL: wmask = M_FREQ_SEL;
			A_GAIN_LOOP: wmask = M_GAIN_LOOP;
			A_LNA_GAIN_HI, A_SUPPLY, A_FEC_EN, A_CLK_MULT_HI: wmask = M_TWO;
			A_REF_CLK: wmask = M_REF_CLK;
			A_CLK_DIV, A_ENC_FRAME_HI, A_DEC_FRAME_HI: wmask = M_SEVEN;
			A_CLK_POST_HI: wmask = M_THREE;
			A_CHIP_EXP, A_CODE_SEL, A_ENC_RATE, A_DEC_RATE: wmask = M_NIBBLE;
			default: wmask = M_FULL;
		endcase
	end

	// Host writes are held off while an image is moved, so a copy is never torn
	assign host_wr = req.wr && (state == ST_IDLE) && (req.addr < LAST_REG);

	// Volatile image wins over non-volatile; no image leaves all zero
	always_comb begin
		if (vol_image[NUM_REGS] == IMAGE_MARK) begin
			load_byte = vol_image[idx];
		end else if (nv_image[NUM_REGS] == IMAGE_MARK) begin
			load_byte = nv_image[idx];
		end else begin
			load_byte = 8'h00;
		end
	end

	// ************************************************************
	// Sequencer for load and save
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_LOAD;
			idx <= 8'h00;
			save_nv <= 1'b0;
			load_done <= 1'b0;
			busy <= 1'b1;
		end else begin
			load_done <= 1'b0;
			case (state)
				ST_LOAD: begin
					if (idx == 8'(NUM_REGS - 1)) begin
						state <= ST_IDLE;
						idx <= 8'h00;
						load_done <= 1'b1;
						busy <= 1'b0;
					end else begin
						idx <= idx + 8'h01;
					end
				end
				ST_IDLE: begin
					if (save_config_volatile_cmd || save_config_nonvolatile_cmd) begin
						state <= ST_SAVE;
						save_nv <= save_config_nonvolatile_cmd;
						idx <= 8'h00;
						busy <= 1'b1;
					end
				end
				ST_SAVE: begin
					if (idx == 8'(NUM_REGS)) begin
						state <= ST_IDLE;
						idx <= 8'h00;
						busy <= 1'b0;
					end else begin
						idx <= idx + 8'h01;
					end
				end
				default: begin
					state <= ST_IDLE;
					busy <= 1'b0;
				end
			endcase
		end
	end

	// Images are not reset, so a warm reset finds the saved contents intact
	always_ff @(posedge clk) begin
		if (state == ST_SAVE) begin
			if (save_nv) begin
				nv_image[idx] <= (idx == 8'(NUM_REGS)) ? IMAGE_MARK : regs[idx];
			end else begin
				vol_image[idx] <= (idx == 8'(NUM_REGS)) ? IMAGE_MARK : regs[idx];
			end
		end
	end

	// ************************************************************
	// Register array
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs[i] <= 8'h00;
			end
		end else if (state == ST_LOAD) begin
			regs[idx] <= load_byte;
		end else if (host_wr) begin
			regs[req.addr] <= req.wdata & wmask;
		end
	end

	// Reads answer one cycle later; past the last register they read zero
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 8'h00;
			rvalid <= 1'b0;
		end else begin
			rvalid <= req.rd;
			rdata <= (req.addr < LAST_REG) ? regs[req.addr] : 8'h00;
		end
	end

	// ************************************************************
	// Trigger decode
	// ************************************************************
	// Triggers fire one cycle after the write so the array already holds every byte
	always_ff @(posedge clk) begin
		if (rst) begin
			apply_sel <= 1'b0;
			apply_rf <= 1'b0;
			apply_if <= 1'b0;
			apply_lna <= 1'b0;
			apply_tx <= 1'b0;
			apply_single <= 1'b0;
			apply_commit <= 1'b0;
		end else begin
			apply_sel <= (host_wr && req.addr == A_FREQ_SEL) || load_done;
			apply_rf <= (host_wr && req.addr == A_RF_GAIN_HI) || load_done;
			apply_if <= (host_wr && req.addr == A_IF_GAIN_HI) || load_done;
			apply_lna <= (host_wr && req.addr == A_LNA_GAIN_HI) || load_done;
			apply_tx <= (host_wr && req.addr == A_TX_LVL_HI) || load_done;
			apply_single <= host_wr || load_done;
			apply_commit <= (host_wr && req.addr == A_COMMIT) || load_done;
		end
	end

	// ************************************************************
	// Active shadow fields
	// ************************************************************
	// Frequency zero sits at 0..3; frequency x above zero at 3+4x..6+4x
	always_comb begin
		if (regs[A_FREQ_SEL][2:0] == 3'h0) begin
			rx_base = 8'h00;
		end else begin
			rx_base = {3'h0, regs[A_FREQ_SEL][2:0], 2'b00} + 8'h03;
		end
		if (regs[A_FREQ_SEL][6:4] == 3'h0) begin
			tx_base = 8'h00;
		end else begin
			tx_base = {3'h0, regs[A_FREQ_SEL][6:4], 2'b00} + 8'h03;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cfg.rx_freq_hz <= 32'h0;
			cfg.tx_freq_hz <= 32'h0;
		end else if (apply_sel) begin
			cfg.rx_freq_hz <= {regs[rx_base + 8'h03], regs[rx_base + 8'h02],
				regs[rx_base + 8'h01], regs[rx_base]};
			cfg.tx_freq_hz <= {regs[tx_base + 8'h03], regs[tx_base + 8'h02],
				regs[tx_base + 8'h01], regs[tx_base]};
		end
	end

	// Gains are held back until their high byte lands
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg.rf_gain <= 12'h0;
			cfg.if_gain <= 12'h0;
			cfg.lna_gain <= 10'h0;
			cfg.tx_level_target <= 12'h0;
		end else begin
			if (apply_rf) begin
				cfg.rf_gain <= {regs[A_RF_GAIN_HI][3:0], regs[A_RF_GAIN_LO]};
			end
			if (apply_if) begin
				cfg.if_gain <= {regs[A_IF_GAIN_HI][3:0], regs[A_IF_GAIN_LO]};
			end
			if (apply_lna) begin
				cfg.lna_gain <= {regs[A_LNA_GAIN_HI][1:0], regs[A_LNA_GAIN_LO]};
			end
			if (apply_tx) begin
				cfg.tx_level_target <= {regs[A_TX_LVL_HI][3:0], regs[A_TX_LVL_LO]};
			end
		end
	end

	// Single-byte settings follow any write, since they cannot be seen half-written
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg.lna_agc_on <= 1'b0;
			cfg.rf_agc_on <= 1'b0;
			cfg.if_agc_mode <= 2'b00;
			cfg.tx_on <= 1'b0;
			cfg.block_supply_on <= 1'b0;
			cfg.block_supply_18v <= 1'b0;
			cfg.front_reference_clock_output <= 1'b0;
			cfg.block_downconverter_clock_output <= 1'b0;
			cfg.tx_reference_clock_output <= 1'b0;
			cfg.fec_enc_en <= 1'b0;
			cfg.fec_dec_en <= 1'b0;
			cfg.enc_payload_bytes <= 8'h0;
			cfg.enc_rate <= 4'h0;
			cfg.dec_payload_bytes <= 8'h0;
			cfg.dec_rate <= 4'h0;
			cfg.dec_max_iter <= 8'h0;
			cfg.clk_div <= 7'h0;
			cfg.chip_rate_exp <= 4'h0;
			cfg.code_select <= 4'h0;
		end else if (apply_single) begin
			cfg.lna_agc_on <= regs[A_GAIN_LOOP][B_LNA_LOOP];
			cfg.rf_agc_on <= regs[A_GAIN_LOOP][B_RF_LOOP];
			cfg.if_agc_mode <= regs[A_GAIN_LOOP][3:2];
			cfg.tx_on <= regs[A_GAIN_LOOP][B_TX_ON];
			cfg.block_supply_on <= regs[A_SUPPLY][B_SUPPLY_ON];
			cfg.block_supply_18v <= regs[A_SUPPLY][B_SUPPLY_18V];
			cfg.front_reference_clock_output <= regs[A_REF_CLK][B_FRONT_CLK];
			cfg.block_downconverter_clock_output <= regs[A_REF_CLK][B_LNB_CLK];
			cfg.tx_reference_clock_output <= regs[A_REF_CLK][B_TX_CLK];
			cfg.fec_enc_en <= regs[A_FEC_EN][B_ENC_EN];
			cfg.fec_dec_en <= regs[A_FEC_EN][B_DEC_EN];
			// Size limits are software's to keep; the value passes as written
			cfg.enc_payload_bytes <= regs[A_ENC_PAYLOAD];
			cfg.enc_rate <= regs[A_ENC_RATE][3:0];
			cfg.dec_payload_bytes <= regs[A_DEC_PAYLOAD];
			cfg.dec_rate <= regs[A_DEC_RATE][3:0];
			cfg.dec_max_iter <= regs[A_DEC_ITER];
			cfg.clk_div <= regs[A_CLK_DIV][6:0];
			cfg.chip_rate_exp <= regs[A_CHIP_EXP][3:0];
			cfg.code_select <= regs[A_CODE_SEL][3:0];
		end
	end

	// Multi-byte settings wait for the commit register
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg.enc_frame_bits <= 15'h0;
			cfg.dec_frame_bits <= 15'h0;
			cfg.clk_mult <= 10'h0;
			cfg.clk_postdiv <= 11'h0;
			cfg.code_period <= 16'h0;
			cfg.first_generator_polynomial <= 24'h0;
		end else if (apply_commit) begin
			cfg.enc_frame_bits <= {regs[A_ENC_FRAME_HI][6:0], regs[A_ENC_FRAME_LO]};
			cfg.dec_frame_bits <= {regs[A_DEC_FRAME_HI][6:0], regs[A_DEC_FRAME_LO]};
			cfg.clk_mult <= {regs[A_CLK_MULT_HI][1:0], regs[A_CLK_MULT_LO]};
			cfg.clk_postdiv <= {regs[A_CLK_POST_HI][2:0], regs[A_CLK_POST_LO]};
			cfg.code_period <= {regs[A_PERIOD_HI], regs[A_PERIOD_LO]};
			cfg.first_generator_polynomial <= {regs[A_POLY_B2], regs[A_POLY_B1],
				regs[A_POLY_B0]};
		end
	end
endmodule

// >>> testbench/dcr_properties.sv
// Port checker for the control register bank
`timescale 1ns/10ps
module dcr_properties #(
	parameter int NUM_FREQ = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire dcr_pkg::dcr_req_t req,
	input wire logic save_config_volatile_cmd,
	input wire logic save_config_nonvolatile_cmd,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	input wire logic busy,
	input wire dcr_pkg::dcr_cfg_t cfg
);
	import dcr_pkg::*;
	logic [2:0] quiet;
	logic wr_ok;
	logic wr_rf;
	logic wr_lna;
	logic wr_sel;
	logic wr_commit;
	assign wr_ok = req.wr && !busy;
	assign wr_rf = wr_ok && req.addr == A_RF_GAIN_HI;
	assign wr_lna = wr_ok && req.addr == A_LNA_GAIN_HI;
	assign wr_sel = wr_ok && req.addr == A_FREQ_SEL;
	assign wr_commit = wr_ok && req.addr == A_COMMIT;
	// Load re-applies every field, so hold checks wait a few idle cycles
	always_ff @(posedge clk) begin
		if (rst || busy) begin
			quiet <= 3'h0;
		end else if (quiet != 3'h7) begin
			quiet <= quiet + 3'h1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_read_answer: assert property (req.rd |=> rvalid)
		else $error("read not answered next cycle");
	a_no_stray: assert property (!req.rd |=> !rvalid)
		else $error("read valid without a read");
	a_sel_reserved: assert property (rvalid && $past(req.addr) == A_FREQ_SEL
		|-> (rdata & ~M_FREQ_SEL) == 8'h00) else $error("reserved select bits set");
	a_rf_apply: assert property (wr_rf
		|=> ##1 {4'h0, cfg.rf_gain[11:8]} == ($past(req.wdata, 2) & 8'h0f))
		else $error("rf gain high nibble not applied");
	a_rf_hold: assert property ($changed(cfg.rf_gain) && quiet > 3'h4
		|-> $past(wr_rf, 2)) else $error("rf gain moved without trigger");
	a_lna_hold: assert property ($changed(cfg.lna_gain) && quiet > 3'h4
		|-> $past(wr_lna, 2)) else $error("lna gain moved without trigger");
	a_freq_hold: assert property ($changed({cfg.rx_freq_hz, cfg.tx_freq_hz})
		&& quiet > 3'h4 |-> $past(wr_sel, 2)) else $error("tuning moved without select");
	a_commit_only: assert property ($changed(cfg.code_period) && quiet > 3'h4
		|-> $past(wr_commit, 2)) else $error("period moved without commit");
	a_save_busy: assert property (!busy
		&& (save_config_volatile_cmd || save_config_nonvolatile_cmd) |=> busy[*8])
		else $error("save not reported busy");
	a_loop_mode: assert property (wr_ok && req.addr == A_GAIN_LOOP |=> ##1
		{4'h0, cfg.if_agc_mode, cfg.rf_agc_on, cfg.lna_agc_on}
		== ($past(req.wdata, 2) & 8'h0f)) else $error("loop modes wrong");
	a_supply_bits: assert property (wr_ok && req.addr == A_SUPPLY |=> ##1
		{6'h0, cfg.block_supply_18v, cfg.block_supply_on}
		== ($past(req.wdata, 2) & 8'h03)) else $error("supply bits wrong");
endmodule
bind dcr_regs dcr_properties #(.NUM_FREQ(NUM_FREQ)) u_props (.clk(clk), .rst(rst),
	.req(req), .save_config_volatile_cmd(save_config_volatile_cmd),
	.save_config_nonvolatile_cmd(save_config_nonvolatile_cmd), .rdata(rdata),
	.rvalid(rvalid), .busy(busy), .cfg(cfg));

// >>> testbench/dcr_regs_tb.sv
// Self-checking bench for the control register bank
`timescale 1ns/10ps
module dcr_regs_tb;
	import dcr_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	dcr_req_t req = '0;
	logic sv_v = 1'b0;
	logic sv_n = 1'b0;
	logic [7:0] rdata;
	logic rvalid;
	logic busy;
	dcr_cfg_t cfg;
	int bad_count = 0;
	int checked = 0;
	// ****************
	// Tables
	// ****************
	logic [7:0] m_a [12] = '{8'h05, 8'h06, 8'h27, 8'h29, 8'h2b, 8'h2e, 8'h30, 8'h34,
		8'h35, 8'h38, 8'ha6, 8'h00};
	logic [7:0] m_m [12] = '{8'h0f, 8'h77, 8'h4f, 8'h03, 8'h03, 8'h0e, 8'h7f, 8'h07,
		8'h0f, 8'h0f, 8'h7f, 8'hff};
	logic [7:0] g_a [4] = '{8'h04, 8'h23, 8'h28, 8'h25};
	logic [31:0] g_e [4] = '{32'hfa5, 32'hfa5, 32'h3a5, 32'hfa5};
	// Payload sizes and iteration limit stay within what software may program
	logic [7:0] s_a [5] = '{8'h30, 8'h35, 8'ha2, 8'ha7, 8'hab};
	logic [7:0] s_d [5] = '{8'h6a, 8'hff, 8'hfe, 8'h0e, 8'h07};
	logic [31:0] s_e [5] = '{32'h6a, 32'hf, 32'hfe, 32'he, 32'h7};
	logic [7:0] c_a [13] = '{8'h36, 8'h37, 8'ha5, 8'ha6, 8'ha9, 8'haa, 8'h31, 8'h32,
		8'h33, 8'h34, 8'h39, 8'h3a, 8'h3b};
	dcr_regs u_dut (.clk(clk), .rst(rst), .req(req), .save_config_volatile_cmd(sv_v),
		.save_config_nonvolatile_cmd(sv_n), .rdata(rdata), .rvalid(rvalid), .busy(busy),
		.cfg(cfg));
	always #5 clk = ~clk;
	// ****************
	// Tasks
	// ****************
	task automatic summarize;
		$display("Mismatches %0d, comparisons %0d", bad_count, checked);
		if (bad_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		chk(rvalid, 1'b1);
		chk(rdata, e);
	endtask
	// Shadow fields land one edge after the write edge
	task automatic st;
		@(posedge clk);
		#1;
	endtask
	task automatic idle;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 400) begin
			st();
			n++;
		end
		if (busy !== 1'b0) begin
			chk(busy, 1'b0);
			summarize();
		end
		repeat (3) @(posedge clk);
	endtask
	task automatic rs;
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk(busy, 1'b1);
		idle();
	endtask
	task automatic save(input logic nv);
		@(posedge clk);
		sv_v <= !nv;
		sv_n <= nv;
		@(posedge clk);
		sv_v <= 1'b0;
		sv_n <= 1'b0;
	endtask
	function automatic logic [31:0] fld(input int k);
		case (k)
			0: return 32'(cfg.rf_gain);
			1: return 32'(cfg.if_gain);
			2: return 32'(cfg.lna_gain);
			3: return 32'(cfg.tx_level_target);
			4: return 32'(cfg.clk_div);
			5: return 32'(cfg.chip_rate_exp);
			6: return 32'(cfg.enc_payload_bytes);
			7: return 32'(cfg.dec_payload_bytes);
			default: return 32'(cfg.dec_max_iter);
		endcase
	endfunction
	function automatic logic [31:0] fx(input int x);
		logic [3:0] n;
		n = 4'(x);
		if (x == 0) begin
			return 32'h83828180;
		end
		return {n, 4'h3, n, 4'h2, n, 4'h1, n, 4'h0};
	endfunction
	// ****************
	// Sequence
	// ****************
	initial begin
		rs();
		for (int i = 0; i < 12; i++) begin
			wr(m_a[i], 8'hff);
			rd(m_a[i], m_m[i]);
		end
		rd(8'hb0, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(g_a[i], 8'h00);
			wr(g_a[i] + 8'h01, 8'h00);
			wr(g_a[i], 8'ha5);
			st();
			chk(fld(i), 32'h0);
			wr(g_a[i] + 8'h01, 8'hff);
			st();
			chk(fld(i), g_e[i]);
		end
		wr(8'h27, 8'h4d);
		st();
		chk({cfg.tx_on, cfg.if_agc_mode, cfg.rf_agc_on, cfg.lna_agc_on}, 5'h1d);
		wr(8'h27, 8'h32);
		st();
		chk({cfg.tx_on, cfg.if_agc_mode, cfg.rf_agc_on, cfg.lna_agc_on}, 5'h02);
		for (int i = 0; i < 2; i++) begin
			wr(8'h2b, i ? 8'h01 : 8'h02);
			wr(8'h2e, i ? 8'h04 : 8'h0a);
			wr(8'h2f, i ? 8'h02 : 8'h01);
			st();
			chk({cfg.block_supply_18v, cfg.block_supply_on, cfg.front_reference_clock_output,
				cfg.block_downconverter_clock_output, cfg.tx_reference_clock_output,
				cfg.fec_dec_en, cfg.fec_enc_en}, i ? 7'h2a : 7'h55);
		end
		for (int c = 0; c < 8; c++) begin
			wr(8'ha4, 8'(c));
			wr(8'ha8, 8'(c));
			st();
			chk({cfg.enc_rate, cfg.dec_rate}, {4'(c), 4'(c)});
		end
		for (int c = 1; c < 5; c++) begin
			wr(8'h38, 8'(c));
			st();
			chk(cfg.code_select, 4'(c));
		end
		for (int i = 0; i < 5; i++) begin
			wr(s_a[i], s_d[i]);
			st();
			chk(fld(i + 4), s_e[i]);
		end
		for (int x = 1; x < 8; x++) begin
			for (int j = 0; j < 4; j++) begin
				wr(8'(3 + 4 * x + j), {4'(x), 4'(j)});
			end
		end
		for (int j = 0; j < 4; j++) begin
			wr(8'(j), 8'h80 + 8'(j));
		end
		for (int x = 0; x < 8; x++) begin
			wr(8'h06, {1'b0, 3'(7 - x), 1'b0, 3'(x)});
			st();
			chk({cfg.rx_freq_hz, cfg.tx_freq_hz}, {fx(x), fx(7 - x)});
		end
		wr(8'h1f, 8'h00);
		st();
		chk(cfg.rx_freq_hz, fx(7));
		wr(8'h06, 8'h07);
		st();
		chk(cfg.rx_freq_hz, fx(7) & 32'hffffff00);
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 13; i++) begin
				wr(c_a[i], p == 0 ? 8'h00 : (i < 10 ? 8'hff : (i == 10 ? 8'h39 : 8'h00)));
			end
			st();
			chk({cfg.code_period, cfg.enc_frame_bits, cfg.dec_frame_bits}, 0);
			chk({cfg.clk_mult, cfg.clk_postdiv, cfg.first_generator_polynomial}, 0);
			wr(8'hac, 8'h00);
		end
		st();
		chk({cfg.code_period, cfg.enc_frame_bits, cfg.dec_frame_bits},
			{16'hffff, 15'h7fff, 15'h7fff});
		chk({cfg.clk_mult, cfg.clk_postdiv, cfg.first_generator_polynomial},
			{10'h3ff, 11'h7ff, 24'h000039});
		wr(8'h2f, 8'h03);
		save(1'b0);
		idle();
		save(1'b1);
		wr(8'h2f, 8'h00);
		idle();
		rd(8'h2f, 8'h03);
		rs();
		rd(8'h2f, 8'h03);
		chk({cfg.fec_dec_en, cfg.fec_enc_en}, 2'h3);
		summarize();
	end
endmodule
